// ---- shared/cfb_pkg.sv ----
// constants for the clock fanout configuration bank
package cfb_pkg;
  // ==========================================================================
  // command codes
  localparam logic [7:0] CFB_CMD_FLAG       = 8'h80;
  localparam logic [6:0] CFB_OFS_LOCK_PHASE = 7'h03;
  localparam logic [6:0] CFB_OFS_G0_DIV     = 7'h04;
  localparam logic [6:0] CFB_OFS_CHIP_OUTS  = 7'h05;
  localparam logic [6:0] CFB_OFS_OUTS_BW    = 7'h06;
  localparam logic [6:0] CFB_OFS_LOOP_DIV   = 7'h07;
  // ==========================================================================
  // reset values
  localparam logic [7:0] CFB_RST_LOCK_PHASE = 8'h00;
  localparam logic [7:0] CFB_RST_G0_DIV     = 8'h27;
  localparam logic [7:0] CFB_RST_CHIP_OUTS  = 8'hFF;
  localparam logic [7:0] CFB_RST_OUTS_BW    = 8'hF0;
  localparam logic [7:0] CFB_RST_LOOP_DIV   = 8'h89;
  // ==========================================================================
  // decoded output reset values
  localparam logic [6:0] CFB_RST_RATIO      = 7'h14;
  localparam logic [5:0] CFB_RST_PHASE_DEN  = 6'h04;
  localparam logic [3:0] CFB_RST_IN_DIV     = 4'h1;
  localparam logic [5:0] CFB_RST_FB_DIV     = 6'h28;
  // ==========================================================================
  // field positions
  localparam int CFB_BIT_LOCK_OVR   = 5;
  localparam int CFB_BIT_G0_EN      = 5;
  localparam int CFB_BIT_G0_BYPASS  = 4;
  localparam int CFB_BIT_CHIP_EN    = 7;
  localparam int CFB_BIT_LOOP_EN    = 7;
  localparam int CFB_NUM_OUTS       = 11;
  localparam int CFB_NUM_GROUP0     = 5;
  // ==========================================================================
  // feedback divider codes
  localparam logic [3:0] CFB_FB_CODE_32 = 4'h8;
  localparam logic [3:0] CFB_FB_CODE_40 = 4'h9;
  // ==========================================================================
  // synchroniser depth
  localparam int CFB_SYNC_STAGES = 2;
endpackage : cfb_pkg

// ---- design/cfb_config_bank.sv ----
// configuration bank, bytes 3 to 7, with field decode
//
// Function
// - lock override ungates outputs from loop lock
// - byte 3 low five bits: group0 phase
// - byte 4 bit 5 enables group0 outputs
// - byte 4 bit 4 bypasses loop
// - byte 4 low nibble: group0 ratio, default 20
// - ratio codes 0..A decode to 1..80 table, codes B..F to 0
// - byte 5 bit 7 chip enable
// - byte 5 bits 6..0 enable outputs 10..4
// - byte 6 bits 7..4 enable outputs 3..0
// - byte 6 low nibble: loop bandwidth select
// - byte 7 bit 7 loop enable
// - byte 7 bits 5..4 input divider 1/2/4/8
// - byte 7 low nibble feedback divider 32/40
// - command code 80h plus byte offset
// - phase lead steps, none for ratio 1, 5
`timescale 1ns/1ps
`default_nettype none
module cfb_config_bank
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [7:0]                  cmd_code,
  input  wire logic                        wr_stb,
  input  wire logic [7:0]                  wr_data,
  input  wire logic                        rd_stb,
  output logic      [7:0]                  rd_data,
  output logic                             rd_valid,
  input  wire logic                        loop_locked,
  output logic      [cfb_pkg::CFB_NUM_OUTS-1:0] out_drive_en,
  output logic                             chip_en,
  output logic                             loop_en,
  output logic      [3:0]                  loop_bw_sel,
  output logic                             group0_loop_bypass,
  output logic      [6:0]                  group0_ratio,
  output logic      [4:0]                  group0_phase_steps,
  output logic      [5:0]                  group0_phase_den,
  output logic      [3:0]                  input_div_ratio,
  output logic      [5:0]                  feedback_div_ratio
);
  import cfb_pkg::*;

  // ==========================================================================
  // register storage
  logic [7:0] lock_gate_phase_group0;
  logic [7:0] group0_divider_ctrl;
  logic [7:0] chip_and_upper_output_enables;
  logic [7:0] lower_output_enables_bandwidth;
  logic [7:0] loop_enable_input_feedback_div;
  logic       cmd_hit;
  logic [6:0] cmd_ofs;

  assign cmd_hit = (cmd_code & CFB_CMD_FLAG) == CFB_CMD_FLAG;
  assign cmd_ofs = cmd_code[6:0];

  // byte 3 write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_gate_phase_group0 <= CFB_RST_LOCK_PHASE;
    end else if (wr_stb && cmd_hit && (cmd_ofs == CFB_OFS_LOCK_PHASE)) begin
      lock_gate_phase_group0 <= wr_data;
    end
  end

  // byte 4 write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      group0_divider_ctrl <= CFB_RST_G0_DIV;
    end else if (wr_stb && cmd_hit && (cmd_ofs == CFB_OFS_G0_DIV)) begin
      group0_divider_ctrl <= wr_data;
    end
  end

  // byte 5 write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_and_upper_output_enables <= CFB_RST_CHIP_OUTS;
    end else if (wr_stb && cmd_hit && (cmd_ofs == CFB_OFS_CHIP_OUTS)) begin
      chip_and_upper_output_enables <= wr_data;
    end
  end

  // byte 6 write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lower_output_enables_bandwidth <= CFB_RST_OUTS_BW;
    end else if (wr_stb && cmd_hit && (cmd_ofs == CFB_OFS_OUTS_BW)) begin
      lower_output_enables_bandwidth <= wr_data;
    end
  end

  // byte 7 write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_enable_input_feedback_div <= CFB_RST_LOOP_DIV;
    end else if (wr_stb && cmd_hit && (cmd_ofs == CFB_OFS_LOOP_DIV)) begin
      loop_enable_input_feedback_div <= wr_data;
    end
  end

  // ==========================================================================
  // read path
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (cmd_hit) begin
      unique case (cmd_ofs)
        CFB_OFS_LOCK_PHASE: rd_mux = lock_gate_phase_group0;
        CFB_OFS_G0_DIV:     rd_mux = group0_divider_ctrl;
        CFB_OFS_CHIP_OUTS:  rd_mux = chip_and_upper_output_enables;
        CFB_OFS_OUTS_BW:    rd_mux = lower_output_enables_bandwidth;
        CFB_OFS_LOOP_DIV:   rd_mux = loop_enable_input_feedback_div;
        default:            rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb) begin
        rd_data <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // lock status synchroniser
  logic [CFB_SYNC_STAGES-1:0] lock_sync;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_sync <= '0;
    end else begin
      lock_sync <= {lock_sync[CFB_SYNC_STAGES-2:0], loop_locked};
    end
  end

  // ==========================================================================
  // field decode
  logic [3:0]              ratio_code;
  logic [4:0]              phase_sel;
  logic [6:0]              next_ratio;
  logic [4:0]              next_steps;
  logic [5:0]              next_den;
  logic [3:0]              next_in_div;
  logic [5:0]              next_fb_div;
  logic [CFB_NUM_OUTS-1:0] out_n_en;
  logic [CFB_NUM_OUTS-1:0] next_drive;
  logic                    lock_gate_override;
  logic                    group0_divider_en;
  logic                    outs_allowed;

  assign ratio_code         = group0_divider_ctrl[3:0];
  assign phase_sel          = lock_gate_phase_group0[4:0];
  assign lock_gate_override = lock_gate_phase_group0[CFB_BIT_LOCK_OVR];
  assign group0_divider_en  = group0_divider_ctrl[CFB_BIT_G0_EN];
  assign out_n_en = {chip_and_upper_output_enables[6:0],
                     lower_output_enables_bandwidth[7:4]};
  assign outs_allowed = chip_and_upper_output_enables[CFB_BIT_CHIP_EN]
                        && (lock_gate_override || lock_sync[CFB_SYNC_STAGES-1]);

  always_comb begin
    next_ratio = 7'h00;
    next_steps = 5'h00;
    next_den   = 6'h01;
    unique case (ratio_code)
      4'h0: next_ratio = 7'h01;
      4'h1: begin
        next_ratio = 7'h02;
        next_steps = {4'h0, phase_sel[0]};
        next_den   = 6'h02;
      end
      4'h2: begin
        next_ratio = 7'h04;
        next_steps = {3'h0, phase_sel[1:0]};
        next_den   = 6'h04;
      end
      4'h3: next_ratio = 7'h05;
      4'h4: begin
        next_ratio = 7'h08;
        next_steps = {2'h0, phase_sel[2:0]};
        next_den   = 6'h08;
      end
      4'h5: begin
        next_ratio = 7'h0A;
        next_steps = {4'h0, phase_sel[1]};
        next_den   = 6'h02;
      end
      4'h6: begin
        next_ratio = 7'h10;
        next_steps = {1'h0, phase_sel[3:0]};
        next_den   = 6'h10;
      end
      4'h7: begin
        next_ratio = 7'h14;
        next_steps = {3'h0, phase_sel[2:1]};
        next_den   = 6'h04;
      end
      4'h8: begin
        next_ratio = 7'h20;
        next_steps = phase_sel;
        next_den   = 6'h20;
      end
      4'h9: begin
        next_ratio = 7'h28;
        next_steps = {2'h0, phase_sel[3:1]};
        next_den   = 6'h08;
      end
      4'hA: begin
        next_ratio = 7'h50;
        next_steps = {1'h0, phase_sel[4:1]};
        next_den   = 6'h10;
      end
      default: ;
    endcase
  end

  always_comb begin
    unique case (loop_enable_input_feedback_div[5:4])
      2'h0:    next_in_div = 4'h1;
      2'h1:    next_in_div = 4'h2;
      2'h2:    next_in_div = 4'h4;
      2'h3:    next_in_div = 4'h8;
    endcase
    if (loop_enable_input_feedback_div[3:0] == CFB_FB_CODE_32) begin
      next_fb_div = 6'h20;
    end else if (loop_enable_input_feedback_div[3:0] == CFB_FB_CODE_40) begin
      next_fb_div = 6'h28;
    end else begin
      next_fb_div = 6'h00;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFB_NUM_OUTS; gi++) begin : g_drive
      if (gi < CFB_NUM_GROUP0) begin : g_grp0
        assign next_drive[gi] = outs_allowed && out_n_en[gi] && group0_divider_en;
      end else begin : g_rest
        assign next_drive[gi] = outs_allowed && out_n_en[gi];
      end
    end
  endgenerate

  // ==========================================================================
  // registered decoded outputs
  // output, chip and loop enables
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_drive_en <= '0;
      chip_en      <= 1'b1;
      loop_en      <= 1'b1;
    end else begin
      out_drive_en <= next_drive;
      chip_en      <= chip_and_upper_output_enables[CFB_BIT_CHIP_EN];
      loop_en      <= loop_enable_input_feedback_div[CFB_BIT_LOOP_EN];
    end
  end

  // loop bandwidth select
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_bw_sel <= 4'h0;
    end else begin
      loop_bw_sel <= lower_output_enables_bandwidth[3:0];
    end
  end

  // group0 divider and phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      group0_loop_bypass <= 1'b0;
      group0_ratio       <= CFB_RST_RATIO;
      group0_phase_steps <= 5'h00;
      group0_phase_den   <= CFB_RST_PHASE_DEN;
    end else begin
      group0_loop_bypass <= group0_divider_ctrl[CFB_BIT_G0_BYPASS];
      group0_ratio       <= next_ratio;
      group0_phase_steps <= next_steps;
      group0_phase_den   <= next_den;
    end
  end

  // input and feedback dividers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_div_ratio    <= CFB_RST_IN_DIV;
      feedback_div_ratio <= CFB_RST_FB_DIV;
    end else begin
      input_div_ratio    <= next_in_div;
      feedback_div_ratio <= next_fb_div;
    end
  end

endmodule // cfb_config_bank
`default_nettype wire

// ---- dv/cfb_config_bank_checker.sv ----
// port checker for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module cfb_config_bank_checker (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  cmd_code,
  input wire logic        wr_stb,
  input wire logic [7:0]  wr_data,
  input wire logic        rd_stb,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic [10:0] out_drive_en,
  input wire logic        chip_en,
  input wire logic        loop_en,
  input wire logic [6:0]  group0_ratio,
  input wire logic [3:0]  input_div_ratio
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_read_pulse: assert property (rd_stb |=> rd_valid)
    else $error("read not answered");
  a_valid_cause: assert property (rd_valid |-> $past(rd_stb))
    else $error("stray read answer");
  a_unmapped_read: assert property (rd_stb && !(cmd_code inside {[8'h83:8'h87]}) |=>
    rd_data == 8'h00) else $error("unmapped read not zero");
  a_chip_gates: assert property (|out_drive_en |-> chip_en)
    else $error("output on with chip off");
  a_chip_write: assert property (wr_stb && cmd_code == 8'h85 |->
    ##2 chip_en == $past(wr_data[7], 2)) else $error("chip enable wrong");
  a_loop_write: assert property (wr_stb && cmd_code == 8'h87 |->
    ##2 loop_en == $past(wr_data[7], 2)) else $error("loop enable wrong");
  a_input_div: assert property (wr_stb && cmd_code == 8'h87 |->
    ##2 input_div_ratio == 4'h1 << $past(wr_data[5:4], 2)) else $error("input divider wrong");
  a_ratio_legal: assert property (group0_ratio inside {7'h00, 7'h01, 7'h02, 7'h04, 7'h05,
    7'h08, 7'h0A, 7'h10, 7'h14, 7'h20, 7'h28, 7'h50}) else $error("illegal ratio");
  c_read: cover property (rd_valid);
  c_lock_on: cover property ($rose(out_drive_en[0]));
  c_ratio_max: cover property (group0_ratio == 7'h50);
endmodule // cfb_config_bank_checker
bind cfb_config_bank cfb_config_bank_checker chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
  .rd_valid(rd_valid), .out_drive_en(out_drive_en), .chip_en(chip_en), .loop_en(loop_en),
  .group0_ratio(group0_ratio), .input_div_ratio(input_div_ratio));
`default_nettype wire

// ---- dv/cfb_host_model.sv ----
// host model for the byte access port
`timescale 1ns/1ps
`default_nettype none
module cfb_host_model (
  input  wire logic       sys_clk,
  output logic      [7:0] cmd_code,
  output logic            wr_stb,
  output logic      [7:0] wr_data,
  output logic            rd_stb
);
  initial {cmd_code, wr_stb, wr_data, rd_stb} = 18'h0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] v);
    @(negedge sys_clk);
    cmd_code = c;
    wr_data = v;
    {wr_stb, rd_stb} = {w, !w};
    @(negedge sys_clk);
    {wr_stb, rd_stb} = 2'h0;
    wr_data = ~v;
  endtask
endmodule // cfb_host_model
`default_nettype wire

// ---- dv/test_cfb_config_bank.sv ----
// self-checking testbench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_cfb_config_bank;
  import cfb_pkg::*;
  logic             sys_clk = 1'b0, reset_n = 1'b0, loop_locked = 1'b0;
  wire logic [7:0]  cmd_code, wr_data, rd_data;
  wire logic        wr_stb, rd_stb, rd_valid, chip_en, loop_en, byp;
  wire logic [10:0] oe;
  wire logic [3:0]  bw, idiv;
  wire logic [6:0]  ratio;
  wire logic [4:0]  steps;
  wire logic [5:0]  den, fb;
  int               miscompares = 0, compares = 0, cycles = 0;
  logic [7:0]       exp_q[$], d;
  logic [7:0]       rst[5] = '{8'h00, 8'h27, 8'hFF, 8'hF0, 8'h89};
  logic [6:0]       rtab[11] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h08, 7'h0A, 7'h10, 7'h14,
                                 7'h20, 7'h28, 7'h50};
  logic [6:0]       r;
  logic [5:0]       dn;
  logic [3:0]       c4;
  cfb_host_model host (.sys_clk(sys_clk), .cmd_code(cmd_code), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb));
  cfb_config_bank uut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_code(cmd_code),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
    .loop_locked(loop_locked), .out_drive_en(oe), .chip_en(chip_en), .loop_en(loop_en),
    .loop_bw_sel(bw), .group0_loop_bypass(byp), .group0_ratio(ratio),
    .group0_phase_steps(steps), .group0_phase_den(den), .input_div_ratio(idiv),
    .feedback_div_ratio(fb));
  task automatic chk(input logic [17:0] seen, input logic [17:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    host.xfer(1'b1, c, v);
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, c, 8'h00);
  endtask
  initial forever #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    cycles++;
    if (rd_valid === 1'b1) chk(rd_data, exp_q.pop_front());
    if (cycles == 4000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(83));
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    chk({chip_en, loop_en, byp, bw, oe}, 18'h30000);
    chk({ratio, fb, idiv}, {7'h14, 6'h28, 4'h1});
    chk({steps, den}, 11'h004);
    for (int i = 0; i < 5; i++) rd(8'(8'h83 + i), rst[i]);
    wr(8'h04, 8'h00);
    wr(8'h82, 8'h55);
    rd(8'h82, 8'h00);
    rd(8'h84, 8'h27);
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      wr(8'h83, d);
      wr(8'h84, {3'h1, i[0], 4'(i)});
      r = (i < 11) ? rtab[i] : 7'h00;
      dn = (r == 7'h00) ? 6'h01 : 6'(r & -r);
      chk({ratio, den, byp}, {r, dn, i[0]});
      chk(steps, 5'((d[4:0] >> (7'(dn) != r)) & (dn - 6'h01)));
      rd(8'h83, d);
    end
    for (int m = 0; m < 4; m++) begin
      d = {m[0], 1'b1, 2'(m), m[0] ? 4'h8 : 4'h9};
      wr(8'h87, d);
      chk({loop_en, idiv, fb}, {m[0], 4'h1 << m, m[0] ? 6'h20 : 6'h28});
      rd(8'h87, d);
    end
    loop_locked = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom) | {k[1], 7'h00};
      c4 = 4'($urandom);
      wr(8'h85, d);
      wr(8'h86, {c4, 4'h0});
      wr(8'h84, {2'h0, k[0], 5'h07});
      chk(oe, {d[6:0], c4} & {11{d[7]}} & {6'h3F, {5{k[0]}}});
    end
    wr(8'h85, 8'hFF);
    wr(8'h86, 8'hF5);
    wr(8'h83, 8'h00);
    loop_locked = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({bw, oe}, 15'h2800);
    wr(8'h83, 8'h20);
    chk(oe, 11'h7FF);
    chk(18'(exp_q.size()), 18'h0);
    give_verdict();
  end
endmodule // test_cfb_config_bank
`default_nettype wire
